// ===== src/fdm_map.svh
// Register offsets, field positions, reset values and timing counts of the damper monitor
`ifndef FDM_MAP_SVH
`define FDM_MAP_SVH

// Register word indices on the plain register port
`define FDM_REG_CTRL        4'h0
`define FDM_REG_CMD         4'h1
`define FDM_REG_STATUS      4'h2
`define FDM_REG_ALARM       4'h3
`define FDM_REG_DFAULT      4'h4

// Control register fields
`define FDM_CTRL_MAP_LSB    0
`define FDM_CTRL_DELAY_BIT  2
`define FDM_CTRL_OFFS_BIT   3
`define FDM_CTRL_NET_BIT    4
`define FDM_CTRL_BAUD_BIT   5
`define FDM_CTRL_ADDR_LSB   8
`define FDM_CTRL_RST        32'h0000_0000
`define FDM_ADDR_MAX        8'hf7

// Command register fields
`define FDM_CMD_RESET_BIT   0
`define FDM_CMD_TEST_BIT    1
`define FDM_CMD_EXTAB_BIT   2
`define FDM_CMD_EXTCD_BIT   3
`define FDM_CMD_NIGHT_BIT   4

// Detector to damper mapping modes
`define FDM_MAP_SEPARATE    2'h0
`define FDM_MAP_AB          2'h1
`define FDM_MAP_CD          2'h2
`define FDM_MAP_ALL         2'h3

// Time base and blink pattern figures
`define FDM_CLK_HZ          125000000
`define FDM_TICK_MS         100
`define FDM_TICK_CYCLES     (`FDM_CLK_HZ / 1000 * `FDM_TICK_MS)
`define FDM_LONG_MS         2000
`define FDM_SHORT_MS        500
`define FDM_LONG_TICKS      (`FDM_LONG_MS / `FDM_TICK_MS)
`define FDM_SHORT_TICKS     (`FDM_SHORT_MS / `FDM_TICK_MS)

// Test schedule figures
`define FDM_INTERVAL_H      48
`define FDM_OFFSET_H        12
`define FDM_DELAY_MIN       5
`define FDM_INTERVAL_TICKS  (`FDM_INTERVAL_H * 3600 * (1000 / `FDM_TICK_MS))
`define FDM_OFFSET_TICKS    (`FDM_OFFSET_H * 3600 * (1000 / `FDM_TICK_MS))
`define FDM_DELAY_TICKS     (`FDM_DELAY_MIN * 60 * (1000 / `FDM_TICK_MS))
`define FDM_MOTION_TICKS    600
`define FDM_LAMP_TICKS      30

`endif

// ===== src/fdm_pkg.sv
// Types shared by the damper monitor files
package fdm_pkg;

  typedef enum logic [2:0] {
    ST_CHECK, ST_IDLE, ST_DELAY, ST_AB_CLOSE, ST_AB_OPEN, ST_CD_CLOSE, ST_CD_OPEN
  } fdm_state_t;

  typedef struct packed {
    logic [7:0] alarm;
    logic [7:0] loop_open;
    logic [7:0] loop_short;
    logic [7:0] dirty;
  } fdm_det_t;

  typedef struct packed {
    logic [7:0] opened;
    logic [7:0] closed;
    logic [7:0] absent;
    logic [7:0] overload;
  } fdm_dmp_t;

  typedef struct packed {
    logic ext_ab;
    logic ext_cd;
    logic ext_test;
    logic night;
    logic power_fail;
    logic reset_btn;
    logic sys_fault;
  } fdm_pins_t;

  typedef struct packed {
    logic       operation;
    logic       vent;
    logic       night;
    logic       test;
    logic       outside_alarm_indicator;
    logic [7:0] pos;
    logic [7:0] fault;
    logic [7:0] det_fault;
    logic [7:0] det_alarm;
    logic [7:0] det_service;
  } fdm_leds_t;

  typedef struct packed {
    logic main_alarm;
    logic service;
    logic vent;
  } fdm_relay_t;

endpackage

// ===== src/fdm_blink.sv
// Time base and blink pattern generator for the damper monitor indicators
`timescale 1ns/1ns
`include "fdm_map.svh"
module fdm_blink #(
  parameter int TICK_CYCLES = `FDM_TICK_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  output logic      tick,
  output logic      pat_long,
  output logic      pat_short,
  output logic      pat_fast
);
  localparam logic [4:0] LONG_T  = 5'(`FDM_LONG_TICKS);
  localparam logic [4:0] SHORT_T = 5'(`FDM_SHORT_TICKS);
  localparam logic [4:0] PERIOD  = 5'(`FDM_LONG_TICKS + `FDM_SHORT_TICKS);

  logic [23:0] cnt_reg;
  logic [4:0]  phase_reg;
  logic        fast_reg;
  logic        wrap;

  // One tick per tenth of a second; every pattern is a whole number of ticks
  assign wrap      = (cnt_reg == 24'(TICK_CYCLES - 1));
  assign tick      = clk_en & wrap;
  assign pat_long  = (phase_reg < LONG_T);
  assign pat_short = (phase_reg < SHORT_T);
  assign pat_fast  = fast_reg;

  // Prescaler, slow phase and fast toggle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_reg   <= 24'h000000;
      phase_reg <= 5'h00;
      fast_reg  <= 1'b1;
    end else if (clk_en) begin
      cnt_reg <= wrap ? 24'h000000 : cnt_reg + 24'h000001;
      if (wrap) begin
        phase_reg <= (phase_reg == PERIOD - 5'h01) ? 5'h00 : phase_reg + 5'h01;
        fast_reg  <= ~fast_reg;
      end
    end
  end
endmodule // fdm_blink

// ===== src/fdm_top.sv
// Fire damper monitor: alarm mapping, test scheduler, relays, indicators, registers
`timescale 1ns/1ns
`include "fdm_map.svh"
// What this block does
// - Run an automatic damper test every 48 hours from power-up or reset.
// - Every test exercises groups A and B first, then C and D.
// - Mapping switch joins detector groups: separate, A+B, C+D, or all together.
// - A shorted or open detector loop closes every connected damper.
// - Two outside alarm inputs force alarm for A+B and for C+D.
// - Main alarm relay on loop, detector, damper, outside, power, system, link faults.
// - Service relay on any dirty detector.
// - Operation lamp steady, 2/0.5 networked, 0.1/0.1 link fault, off on power loss.
// - Test lamp steady for internal tests, 2/0.5 for externally started tests.
// - Position lamp steady open, 2/0.5 closed, 0.1/0.1 middle, off motor missing.
// - Fault lamp steady no-open, 2/0.5 no-close, 0.1 neither, 0.5/2 both sensed.
// - Position lamp off: pair flashes 0.1 on overload, 2/0.5 on motor failure.
// - Loop fault lamp steady for open loop, 0.1/0.1 for shorted loop.
// - Per loop alarm lamp lit once a detector there triggers, until reset.
// - Outside alarm lamp follows outside alarms; night lamp follows night input standalone, night command networked.
// - Reset clears alarms, self-checks, lights lamps, pulses relays, tests A+B then C+D.
// - Outside test input clears only outside alarms, and only when standalone.
// - Night input (night command when networked) closes dampers without alarm and holds the ventilation relay.
// - Ventilation relay on during tests and alarm operation, not for damper faults.
// - Delay switch postpones the damper part of each test by five minutes.
// - Offset switch: test at start, again 12 hours later, then every 48 hours.
// - Link runs 9600 or 19200 baud, 8 bits even parity, station 0 to 247.
module fdm_top #(
  parameter int TICK_CYCLES    = `FDM_TICK_CYCLES,
  parameter int INTERVAL_TICKS = `FDM_INTERVAL_TICKS,
  parameter int OFFSET_TICKS   = `FDM_OFFSET_TICKS,
  parameter int DELAY_TICKS    = `FDM_DELAY_TICKS,
  parameter int MOTION_TICKS   = `FDM_MOTION_TICKS,
  parameter int LAMP_TICKS     = `FDM_LAMP_TICKS
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire fdm_pkg::fdm_det_t  det_in,
  input  wire fdm_pkg::fdm_dmp_t  dmp_in,
  input  wire fdm_pkg::fdm_pins_t pins_in,
  input  wire logic              link_fault,
  output fdm_pkg::fdm_leds_t     leds,
  output fdm_pkg::fdm_relay_t    relays,
  output logic      [7:0]        dmp_close,
  output logic      [7:0]        link_addr,
  output logic                   link_baud_19200
);
  // Synchronisers: stage one feeds stage two only
  fdm_pkg::fdm_det_t  det_s1, det_s;
  fdm_pkg::fdm_dmp_t  dmp_s1, dmp_s;
  fdm_pkg::fdm_pins_t pin_s1, pin_s;
  logic               test_prev_reg, btn_prev_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      det_s1        <= '0;
      det_s         <= '0;
      dmp_s1        <= '0;
      dmp_s         <= '0;
      pin_s1        <= '0;
      pin_s         <= '0;
      test_prev_reg <= 1'b0;
      btn_prev_reg  <= 1'b0;
    end else if (clk_en) begin
      det_s1        <= det_in;
      det_s         <= det_s1;
      dmp_s1        <= dmp_in;
      dmp_s         <= dmp_s1;
      pin_s1        <= pins_in;
      pin_s         <= pin_s1;
      test_prev_reg <= pin_s.ext_test;
      btn_prev_reg  <= pin_s.reset_btn;
    end
  end

  // Time base and blink patterns
  logic tick, pat_long, pat_short, pat_fast;

  fdm_blink #(.TICK_CYCLES(TICK_CYCLES)) u_blink (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .tick      (tick),
    .pat_long  (pat_long),
    .pat_short (pat_short),
    .pat_fast  (pat_fast)
  );

  // Register decode
  logic [31:0] ctrl_reg, ctrl_next;
  logic [2:0]  cmd_lvl_reg;
  logic        wr_ctrl, wr_cmd, networked, delay_sw, offset_sw;
  logic [1:0]  map_mode;
  logic [7:0]  new_addr;

  assign wr_ctrl   = reg_wr & (reg_addr == `FDM_REG_CTRL);
  assign wr_cmd    = reg_wr & (reg_addr == `FDM_REG_CMD);
  assign map_mode  = ctrl_reg[`FDM_CTRL_MAP_LSB +: 2];
  assign delay_sw  = ctrl_reg[`FDM_CTRL_DELAY_BIT];
  assign offset_sw = ctrl_reg[`FDM_CTRL_OFFS_BIT];
  assign networked = ctrl_reg[`FDM_CTRL_NET_BIT];
  assign new_addr  = reg_wdata[`FDM_CTRL_ADDR_LSB +: 8];
  // An out-of-range station keeps the old one
  assign ctrl_next = (new_addr > `FDM_ADDR_MAX)
                   ? {ctrl_reg[31:16], ctrl_reg[15:8], 2'h0, reg_wdata[5:0]}
                   : {16'h0000, new_addr, 2'h0, reg_wdata[5:0]};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_reg    <= `FDM_CTRL_RST;
      cmd_lvl_reg <= 3'h0;
    end else if (clk_en) begin
      if (wr_ctrl) ctrl_reg <= ctrl_next;
      if (wr_cmd) cmd_lvl_reg <= reg_wdata[`FDM_CMD_NIGHT_BIT:`FDM_CMD_EXTAB_BIT];
    end
  end

  // Commands and derived pin levels
  logic remote_reset, remote_test, ext_rise, restart, clr_all, ext_clr;
  logic ext_ab, ext_cd, night;

  assign remote_reset = wr_cmd & reg_wdata[`FDM_CMD_RESET_BIT] & networked;
  assign remote_test  = wr_cmd & reg_wdata[`FDM_CMD_TEST_BIT];
  assign ext_rise     = pin_s.ext_test & ~test_prev_reg;
  assign restart      = (pin_s.reset_btn & ~btn_prev_reg) | remote_reset;
  assign clr_all      = restart;
  assign ext_clr      = ext_rise & ~networked;
  assign ext_ab       = pin_s.ext_ab | (networked & cmd_lvl_reg[0]);
  assign ext_cd       = pin_s.ext_cd | (networked & cmd_lvl_reg[1]);
  assign night        = networked ? cmd_lvl_reg[2] : pin_s.night;

  // Latched alarm conditions; a cause present in the clear cycle wins
  logic [7:0] det_alm_l, open_l, short_l, dirty_l;
  logic       ext_ab_l, ext_cd_l, pwr_l, sys_l, link_l;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      det_alm_l <= 8'h00;
      open_l    <= 8'h00;
      short_l   <= 8'h00;
      dirty_l   <= 8'h00;
      ext_ab_l  <= 1'b0;
      ext_cd_l  <= 1'b0;
      pwr_l     <= 1'b0;
      sys_l     <= 1'b0;
      link_l    <= 1'b0;
    end else if (clk_en) begin
      det_alm_l <= (det_alm_l & ~{8{clr_all}}) | det_s.alarm;
      open_l    <= (open_l & ~{8{clr_all}}) | det_s.loop_open;
      short_l   <= (short_l & ~{8{clr_all}}) | det_s.loop_short;
      dirty_l   <= (dirty_l & ~{8{clr_all}}) | det_s.dirty;
      ext_ab_l  <= (ext_ab_l & ~(clr_all | ext_clr)) | ext_ab;
      ext_cd_l  <= (ext_cd_l & ~(clr_all | ext_clr)) | ext_cd;
      pwr_l     <= (pwr_l & ~clr_all) | pin_s.power_fail;
      sys_l     <= (sys_l & ~clr_all) | pin_s.sys_fault;
      link_l    <= (link_l & ~clr_all) | (networked & link_fault);
    end
  end

  // Detector groups mapped onto damper groups
  logic [3:0] grp_det, grp_map, grp_alarm;
  logic       loop_any, all_force;

  assign grp_det   = {|det_alm_l[7:6], |det_alm_l[5:4], |det_alm_l[3:2], |det_alm_l[1:0]};
  assign grp_map   = (map_mode == `FDM_MAP_SEPARATE) ? grp_det
                   : (map_mode == `FDM_MAP_AB) ? {grp_det[3:2], {2{|grp_det[1:0]}}}
                   : (map_mode == `FDM_MAP_CD) ? {{2{|grp_det[3:2]}}, grp_det[1:0]}
                   : {4{|grp_det}};
  assign loop_any  = |(open_l | short_l);
  assign all_force = loop_any | link_l;
  assign grp_alarm = grp_map | {4{all_force}} | {{2{ext_cd_l}}, {2{ext_ab_l}}};

  // Test sequencer
  fdm_pkg::fdm_state_t state_reg, state_next;
  logic [11:0] phase_reg;
  logic [11:0] phase_lim;
  logic        phase_done, test_req, test_start, test_ext_reg, test_active, lamp;
  logic [3:0]  test_close;

  assign phase_lim  = (state_reg == fdm_pkg::ST_CHECK) ? 12'(LAMP_TICKS)
                    : (state_reg == fdm_pkg::ST_DELAY) ? 12'(DELAY_TICKS)
                    : 12'(MOTION_TICKS);
  assign phase_done = tick & (phase_reg == phase_lim - 12'h001);
  assign lamp       = (state_reg == fdm_pkg::ST_CHECK);
  assign test_active = ~lamp & (state_reg != fdm_pkg::ST_IDLE);
  // Groups A and B are exercised before C and D
  assign test_close = {{2{state_reg == fdm_pkg::ST_CD_CLOSE}},
                       {2{state_reg == fdm_pkg::ST_AB_CLOSE}}};

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      fdm_pkg::ST_CHECK:    if (phase_done) begin
        state_next = delay_sw ? fdm_pkg::ST_DELAY : fdm_pkg::ST_AB_CLOSE;
      end
      fdm_pkg::ST_IDLE:     if (test_req) begin
        state_next = delay_sw ? fdm_pkg::ST_DELAY : fdm_pkg::ST_AB_CLOSE;
      end
      fdm_pkg::ST_DELAY:    if (phase_done) state_next = fdm_pkg::ST_AB_CLOSE;
      fdm_pkg::ST_AB_CLOSE: if (phase_done) state_next = fdm_pkg::ST_AB_OPEN;
      fdm_pkg::ST_AB_OPEN:  if (phase_done) state_next = fdm_pkg::ST_CD_CLOSE;
      fdm_pkg::ST_CD_CLOSE: if (phase_done) state_next = fdm_pkg::ST_CD_OPEN;
      fdm_pkg::ST_CD_OPEN:  if (phase_done) state_next = fdm_pkg::ST_IDLE;
    endcase
    if (restart) state_next = fdm_pkg::ST_CHECK;
  end

  // State, phase timer, and origin of the running test
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg    <= fdm_pkg::ST_CHECK;
      phase_reg    <= 12'h000;
      test_ext_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      if (state_next != state_reg) phase_reg <= 12'h000;
      else if (tick) phase_reg <= phase_reg + 12'h001;
      if (lamp) test_ext_reg <= 1'b0;
      else if (test_start) test_ext_reg <= ext_rise;
    end
  end

  // Scheduler counts from the end of each reset check
  logic [20:0] sched_reg, sched_lim;
  logic        first_reg, due_reg, sched_hit;

  assign sched_lim  = (first_reg & offset_sw) ? 21'(OFFSET_TICKS) : 21'(INTERVAL_TICKS);
  assign sched_hit  = tick & (sched_reg == sched_lim - 21'h000001);
  assign test_req   = due_reg | ext_rise | remote_test;
  assign test_start = (state_reg == fdm_pkg::ST_IDLE) & test_req & ~restart;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sched_reg <= 21'h000000;
      first_reg <= 1'b1;
      due_reg   <= 1'b0;
    end else if (clk_en) begin
      if (lamp) begin
        sched_reg <= 21'h000000;
        first_reg <= 1'b1;
        due_reg   <= 1'b0;
      end else begin
        sched_reg <= sched_hit ? 21'h000000 : sched_reg + {20'h00000, tick};
        if (sched_hit) first_reg <= 1'b0;
        due_reg <= sched_hit | (due_reg & ~test_start);
      end
    end
  end

  // Per damper command, motion supervision and indicators
  logic [7:0] close_cmd, fo_l, fc_l, both_l, pos_led, fault_led;

  genvar d;
  generate
    for (d = 0; d < 8; d++) begin : g_dmp
      localparam int G = d / 2;
      localparam int P = d ^ 1;
      logic [11:0] age_reg;
      logic        prev_reg, at_open, at_closed, check, pos_on, ov_pair;

      // Night closes dampers without any alarm; tests close their own group
      assign close_cmd[d] = grp_alarm[G] | night | test_close[G];
      assign at_open      = dmp_s.opened[d] & ~dmp_s.closed[d];
      assign at_closed    = dmp_s.closed[d] & ~dmp_s.opened[d];
      assign check        = tick & (age_reg == 12'(MOTION_TICKS) - 12'h001) & ~dmp_s.absent[d];
      assign pos_on       = ~dmp_s.absent[d] & ~dmp_s.overload[d];
      assign ov_pair      = dmp_s.overload[d] | dmp_s.overload[P];
      assign pos_led[d]   = ~pos_on ? 1'b0 : at_open ? 1'b1
                          : at_closed ? pat_long : pat_fast;
      // Overload flashes both lamps of the pair, so it outranks local causes
      assign fault_led[d] = ov_pair ? pat_fast
                          : ~pos_on ? (dmp_s.absent[d] ? pat_long : 1'b0)
                          : both_l[d] ? pat_short
                          : (fo_l[d] & fc_l[d]) ? pat_fast
                          : fo_l[d] ? 1'b1 : fc_l[d] ? pat_long : 1'b0;

      // Travel timer restarts on each change of command
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          age_reg  <= 12'h000;
          prev_reg <= 1'b0;
          fo_l[d]  <= 1'b0;
          fc_l[d]  <= 1'b0;
          both_l[d] <= 1'b0;
        end else if (clk_en) begin
          prev_reg <= close_cmd[d];
          if (prev_reg != close_cmd[d]) age_reg <= 12'h000;
          else if (tick & (age_reg != 12'(MOTION_TICKS))) age_reg <= age_reg + 12'h001;
          fo_l[d]   <= (fo_l[d] & ~clr_all) | (check & ~close_cmd[d] & ~at_open);
          fc_l[d]   <= (fc_l[d] & ~clr_all) | (check & close_cmd[d] & ~at_closed);
          both_l[d] <= (both_l[d] & ~clr_all) | (dmp_s.opened[d] & dmp_s.closed[d]);
        end
      end
    end
  endgenerate

  // Alarm summaries; damper faults stay off the ventilation path
  logic dmp_fault_any, main_src, alarm_op;
  logic [7:0] det_fault_led;

  assign dmp_fault_any = |(fo_l | fc_l | both_l);
  assign main_src      = loop_any | (|det_alm_l) | dmp_fault_any | ext_ab_l | ext_cd_l
                       | pwr_l | sys_l | link_l;
  assign alarm_op      = |grp_alarm;
  assign det_fault_led = open_l | (short_l & {8{pat_fast}});

  // Registered relays, damper drives and lamps; reset check lights everything
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      relays    <= '0;
      dmp_close <= 8'h00;
      leds      <= '0;
    end else if (clk_en) begin
      relays.main_alarm <= lamp | main_src;
      relays.service    <= lamp | (|dirty_l);
      relays.vent       <= lamp | test_active | alarm_op | night;
      dmp_close         <= lamp ? 8'h00 : close_cmd;
      if (lamp) begin
        leds <= '1;
      end else begin
        leds.operation <= pin_s.power_fail ? 1'b0 : link_l ? pat_fast
                        : networked ? pat_long : 1'b1;
        leds.vent      <= test_active | alarm_op | night;
        leds.night     <= night;
        leds.test      <= test_active & (test_ext_reg ? pat_long : 1'b1);
        leds.outside_alarm_indicator <= ext_ab_l | ext_cd_l;
        leds.pos       <= pos_led;
        leds.fault     <= fault_led;
        leds.det_fault <= det_fault_led;
        leds.det_alarm <= det_alm_l;
        leds.det_service <= dirty_l;
      end
    end
  end

  // Read selection; data stand only in the cycle after the strobe
  logic [31:0] rd_word;

  assign rd_word = (reg_addr == `FDM_REG_CTRL) ? ctrl_reg
                 : (reg_addr == `FDM_REG_CMD) ? {27'h0000000, cmd_lvl_reg, 2'h0}
                 : (reg_addr == `FDM_REG_STATUS)
                   ? {22'h000000, alarm_op, night, first_reg, test_ext_reg,
                      3'(state_reg), relays}
                 : (reg_addr == `FDM_REG_ALARM)
                   ? {(fo_l | fc_l | both_l), dirty_l, (open_l | short_l), det_alm_l}
                 : (reg_addr == `FDM_REG_DFAULT)
                   ? {4'h0, ext_ab_l, ext_cd_l, pwr_l, sys_l | link_l, both_l, fc_l, fo_l}
                 : 32'h00000000;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_word : 32'h00000000;
    end
  end

  // Link settings for the serial front end, fixed 8 bits even parity
  assign link_addr       = ctrl_reg[`FDM_CTRL_ADDR_LSB +: 8];
  assign link_baud_19200 = ctrl_reg[`FDM_CTRL_BAUD_BIT];
endmodule // fdm_top

// ===== tb/fdm_damper_model.sv
// Damper actuator model: end switches follow the close command after travel
`timescale 1ns/1ns
module fdm_damper_model #(
  parameter int TRAVEL = 6
) (
  input  wire logic         ref_clk,
  input  wire logic [7:0]   dmp_close,
  output fdm_pkg::fdm_dmp_t dmp_out
);
  logic [7:0] cmd_reg = 8'h00;
  int         cnt     = 0;
  // Restart travel on any command change; one shared timer keeps it small
  always_ff @(posedge ref_clk) begin
    cmd_reg <= dmp_close;
    if (dmp_close != cmd_reg)
      cnt <= TRAVEL;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  // Mid position while moving: neither switch made, so a slow flap looks real
  assign dmp_out = {(cnt == 0) ? ~cmd_reg : 8'h00, (cnt == 0) ? cmd_reg : 8'h00, 16'h0000};
endmodule // fdm_damper_model

// ===== tb/fdm_top_assertions.sv
// Port-level assertions for the damper monitor
`timescale 1ns/1ns
module fdm_chk (
  input wire logic                ref_clk,
  input wire logic                sys_rst,
  input wire logic [3:0]          reg_addr,
  input wire logic [31:0]         reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [31:0]         reg_rdata,
  input wire fdm_pkg::fdm_det_t   det_in,
  input wire fdm_pkg::fdm_dmp_t   dmp_in,
  input wire fdm_pkg::fdm_pins_t  pins_in,
  input wire fdm_pkg::fdm_relay_t relays,
  input wire logic [7:0]          dmp_close,
  input wire logic [7:0]          link_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside answer");
  a_unmapped_read: assert property (reg_rd && reg_addr > 4'h4 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_station_write: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[15:8] <= 8'hf7
    |=> link_addr == $past(reg_wdata[15:8])) else $error("station not taken");
  a_station_refuse: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[15:8] > 8'hf7
    |=> $stable(link_addr)) else $error("station above limit taken");
  a_loop_close: assert property ((|(det_in.loop_open | det_in.loop_short)) && !(|dmp_in.absent)
    |-> ##[1:6] dmp_close == 8'hff) else $error("loop fault left a damper open");
  a_loop_main: assert property (|(det_in.loop_open | det_in.alarm) |-> ##[1:6] relays.main_alarm)
    else $error("main relay missing");
  a_dirty_service: assert property (|det_in.dirty |-> ##[1:6] relays.service)
    else $error("service relay missing");
  a_ext_ab: assert property (pins_in.ext_ab |-> ##[1:6] dmp_close[3:0] == 4'hf)
    else $error("outside alarm left first half open");
  a_ext_cd: assert property (pins_in.ext_cd |-> ##[1:6] dmp_close[7:4] == 4'hf)
    else $error("outside alarm left second half open");
endmodule // fdm_chk
bind fdm_top fdm_chk u_fdm_chk (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .det_in, .dmp_in, .pins_in, .relays, .dmp_close, .link_addr);

// ===== tb/fdm_top_bench.sv
// Self-checking bench for the damper monitor
`timescale 1ns/1ns
module fdm_top_bench;
  logic                ref_clk = 1'b0;
  logic                sys_rst = 1'b1;
  logic [3:0]          reg_addr = 4'h0;
  logic [31:0]         reg_wdata = 32'h0, reg_rdata, rd_word;
  logic                reg_wr = 1'b0, reg_rd = 1'b0, clk_en = 1'b1, link_fault = 1'b0;
  logic                link_baud_19200;
  fdm_pkg::fdm_leds_t  leds;
  fdm_pkg::fdm_det_t   det_in = '0;
  fdm_pkg::fdm_pins_t  pins_in = '0;
  fdm_pkg::fdm_dmp_t   dmp_in;
  fdm_pkg::fdm_relay_t relays;
  logic [7:0]          dmp_close, link_addr, seen_q[$];
  logic [7:0]          exp_order[4] = '{8'h0f, 8'h00, 8'hf0, 8'h00};
  int                  bad_count = 0, checks_done = 0, seed = 32'h1043cc54, k, i, b;
  fdm_top #(.TICK_CYCLES(4), .INTERVAL_TICKS(2000), .DELAY_TICKS(5), .MOTION_TICKS(8),
    .LAMP_TICKS(3)) u_fdm_top (.ref_clk, .sys_rst, .clk_en, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .det_in, .dmp_in, .pins_in, .link_fault,
    .leds, .relays, .dmp_close, .link_addr, .link_baud_19200);
  fdm_damper_model u_fdm_damper_model (.ref_clk, .dmp_close, .dmp_out(dmp_in));
  // Free-running 125 MHz clock
  initial forever #4 ref_clk = ~ref_clk;
  task automatic close_out();
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd_word = reg_rdata;
  endtask
  task automatic wait_idle();
    for (k = 0; k < 400; k++) begin
      rd(4'h2);
      if (rd_word[5:3] === 3'h1)
        return;
    end
    bad_count++;
    close_out();
  endtask
  // Records each change of the close command during one test run
  task automatic order_check();
    logic [7:0] last;
    last = 8'h00;
    seen_q = {};
    for (k = 0; k < 600 && seen_q.size() < 4; k++) begin
      @(posedge ref_clk);
      #1;
      if (dmp_close !== last) begin
        last = dmp_close;
        seen_q.push_back(last);
      end
    end
    chk(32'(seen_q.size()), 32'h4);
    foreach (seen_q[j]) chk(seen_q[j], exp_order[j]);
  endtask
  // Expected closures: kind 0..3 detector per map mode, 4 loop, 5 dirty, 6/7 outside
  function automatic logic [7:0] exp_close(int n, int loop);
    if (n == 5)
      return 8'h00;
    if (n == 6 || (n == 1 && loop < 4))
      return 8'h0f;
    if (n == 7 || (n == 2 && loop > 3))
      return 8'hf0;
    if (n == 3 || n == 4)
      return 8'hff;
    return 8'h03 << (2 * (loop / 2));
  endfunction
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(4'h0);
    chk(rd_word, 32'h0);
    order_check();
    wait_idle();
    wr(4'h1, 32'h2);
    order_check();
    wait_idle();
    wr(4'h0, 32'h0000_2a20);
    #1 chk(link_addr, 8'h2a);
    chk(link_baud_19200, 1'b1);
    wr(4'h0, 32'h0000_f800);
    #1 chk(link_addr, 8'h2a);
    chk(link_baud_19200, 1'b0);
    rd(4'h7);
    chk(rd_word, 32'h0);
    // Frozen clock enable: a read strobe must leave the read data at zero
    clk_en <= 1'b0;
    rd(4'h2);
    chk(rd_word, 32'h0);
    clk_en <= 1'b1;
    // Network fault forces every group into alarm; a remote reset clears it
    wr(4'h0, 32'h10);
    link_fault <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 chk(dmp_close, 8'hff);
    chk(relays, 3'b101);
    link_fault <= 1'b0;
    wr(4'h1, 32'h1);
    wait_idle();
    chk(relays, 3'b000);
    for (i = 0; i < 8; i++) begin
      b = $unsigned($random(seed)) % 8;
      wr(4'h0, (i < 4) ? i : 0);
      case (i)
        4: det_in.loop_open[b] <= 1'b1;
        5: det_in.dirty[b] <= 1'b1;
        6: pins_in.ext_ab <= 1'b1;
        7: pins_in.ext_cd <= 1'b1;
        default: det_in.alarm[b] <= 1'b1;
      endcase
      repeat (8) @(posedge ref_clk);
      #1 chk(dmp_close, exp_close(i, b));
      chk(relays, (i == 5) ? 3'b010 : 3'b101);
      chk(leds.det_alarm, (i < 4) ? 8'h01 << b : 8'h00);
      chk(leds.outside_alarm_indicator, i > 5);
      @(posedge ref_clk);
      det_in <= '0;
      pins_in <= '0;
      repeat (8) @(posedge ref_clk);
      #1 chk(relays, (i == 5) ? 3'b010 : 3'b101);
      @(posedge ref_clk);
      pins_in.reset_btn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      pins_in.reset_btn <= 1'b0;
      wait_idle();
      chk(relays, 3'b000);
    end
    close_out();
  end
endmodule // fdm_top_bench
